// ---- src/opaddr_params.svh ----
// Constants of the operand address decoder.
// Assumes inclusion by the decoder module only.
`ifndef OPADDR_PARAMS_SVH
`define OPADDR_PARAMS_SVH
`define STEP_BYTE     32'h0000_0001
`define STEP_WORD     32'h0000_0002
`define STEP_LONG     32'h0000_0004
`define PC_LONG_MASK  32'hFFFF_FFFC
`define IMM20_SHIFT   8
`define FLD_DEST_HI   11
`define FLD_DEST_LO   8
`define FLD_SRC_HI    7
`define FLD_SRC_LO    4
`endif

// ---- src/opaddr_pkg.sv ----
// Types shared by the operand address decoder and its bench.
// Assumes opaddr_params.svh is on the include path.
package opaddr_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } access_size_t;

  typedef enum logic [4:0] {
    M_REG_DIRECT  = 5'b00000,
    M_REG_IND     = 5'b00001,
    M_POST_INC    = 5'b00010,
    M_PRE_DEC     = 5'b00011,
    M_DISP4       = 5'b00100,
    M_DISP12      = 5'b00101,
    M_IDX_REG     = 5'b00110,
    M_GBR_DISP    = 5'b00111,
    M_GBR_IDX     = 5'b01000,
    M_TBR_DBL     = 5'b01001,
    M_PC_DISP     = 5'b01010,
    M_PC_REL8     = 5'b01011,
    M_PC_REL12    = 5'b01100,
    M_PC_REG      = 5'b01101,
    M_IMM20       = 5'b01110,
    M_IMM20S      = 5'b01111,
    M_IMM8_ZX     = 5'b10000,
    M_IMM8_SX     = 5'b10001,
    M_TRAP        = 5'b10010,
    M_BIT3        = 5'b10011,
    M_MAC         = 5'b10100
  } addr_mode_t;

  typedef struct packed {
    addr_mode_t   mode;
    access_size_t size;
    logic [31:0]  insn;
  } dec_req_t;

  typedef struct packed {
    logic [31:0] dest_general_reg;
    logic [31:0] src_general_reg;
    logic [31:0] index_reg_zero;
    logic [31:0] global_base_reg;
    logic [31:0] jump_table_base_reg;
    logic [31:0] pc;
  } reg_vals_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  dest_idx;
    logic [3:0]  src_idx;
    logic        use_reg;
    logic        mem_access;
    logic [31:0] eff_addr;
    logic        wb_en;
    logic [3:0]  wb_idx;
    logic [31:0] wb_val;
    logic        wb2_en;
    logic [3:0]  wb2_idx;
    logic [31:0] wb2_val;
    logic        indirect;
    logic        acc_dest;
    logic [31:0] imm;
    logic [2:0]  bit_pos;
  } dec_out_t;
endpackage : opaddr_pkg

// ---- src/operand_address_decoder.sv ----
// Operand address decoder: fields, effective addresses, base updates and
// immediates, registered one cycle after each request.
// Assumes the decode stage gives mode, size and instruction word (16-bit
// forms in bits 15:0, 32-bit forms with first halfword in bits 31:16),
// and that register values read for the named registers arrive alongside.
// Operation
// [RQ1] Register direct selects the named register, no memory access.
// [RQ2] Register indirect uses the register contents unchanged as address.
// [RQ3] Post-increment addresses with base, then adds 1, 2 or 4 after.
// [RQ4] Pre-decrement subtracts 1, 2 or 4, writes back, uses reduced value.
// [RQ5] Short displacement: zero-extend 4 bits, scale by size, add to base.
// [RQ6] Long displacement: zero-extend 12 bits, add unscaled to base.
// [RQ7] Indexed indirect adds named register and register zero.
// [RQ8] Global-base displacement: zero-extend 8 bits, scale by size, add.
// [RQ9] Indexed global-base adds global base and register zero.
// [RQ10] Table double-indirect: base plus disp times 4, fetch target there.
// [RQ11] Counter offset: word doubles, long quadruples, counter masked.
// [RQ12] Short branch: sign-extend 8 bits, double, add counter.
// [RQ13] Long branch: sign-extend 12 bits, double, add counter.
// [RQ14] Far branch target is counter plus named register.
// [RQ15] Plain 20-bit immediate is sign-extended to 32 bits.
// [RQ16] Shifted 20-bit immediate sits in bits 27:8, zeros below.
// [RQ17] Test and logic immediates are zero-extended from 8 bits.
// [RQ18] Move, add and equality compare immediates are sign-extended.
// [RQ19] Trap immediate is zero-extended and multiplied by four.
// [RQ20] Bit operations take the 3-bit field as target bit position.
// [RQ21] Three-field format: dest 11:8, source 7:4, displacement 3:0.
// [RQ22] Accumulate ops: two post-increment pointers, accumulators as target.
// [RQ23] 32-bit immediate load joins first-halfword bits with second halfword.
// [RQ24] All address arithmetic is 32 bits, carries out of bit 31 dropped.
`timescale 1ns/10ps
`include "opaddr_params.svh"

module operand_address_decoder
  import opaddr_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire logic      req_valid,
  input  wire dec_req_t  req,
  input  wire reg_vals_t regs,
  output dec_out_t       dec_out
);

  dec_out_t    dec_ff;
  dec_out_t    nxt_dec;
  logic [15:0] hw;
  logic [31:0] step;
  logic [31:0] disp4_scaled;
  logic [31:0] disp8_scaled;
  logic [31:0] pc_disp;
  logic [19:0] imm20;

  // Short forms sit in the low halfword; the 32-bit forms keep their
  // first halfword on top, so the 20-bit immediate forms take their register field from there.
  assign hw = req.insn[15:0];
  assign imm20 = {req.insn[23:20], req.insn[15:0]}; // RQ23

  always_comb begin
    case (req.size)
      SZ_BYTE: step = `STEP_BYTE;
      SZ_WORD: step = `STEP_WORD;
      default: step = `STEP_LONG;
    endcase
  end

  always_comb begin
    case (req.size)
      SZ_BYTE: disp4_scaled = {28'h000_0000, hw[3:0]}; // RQ5
      SZ_WORD: disp4_scaled = {27'h000_0000, hw[3:0], 1'b0}; // RQ5
      default: disp4_scaled = {26'h000_0000, hw[3:0], 2'b00}; // RQ5
    endcase
  end

  always_comb begin
    case (req.size)
      SZ_BYTE: disp8_scaled = {24'h00_0000, hw[7:0]}; // RQ8
      SZ_WORD: disp8_scaled = {23'h00_0000, hw[7:0], 1'b0}; // RQ8
      default: disp8_scaled = {22'h00_0000, hw[7:0], 2'b00}; // RQ8
    endcase
  end

  always_comb begin
    if (req.size == SZ_LONG) begin
      pc_disp = (regs.pc & `PC_LONG_MASK)
                + {22'h00_0000, hw[7:0], 2'b00}; // RQ11
    end else begin
      pc_disp = regs.pc + {23'h00_0000, hw[7:0], 1'b0}; // RQ11
    end
  end

  always_comb begin
    nxt_dec            = '0;
    nxt_dec.valid      = req_valid;
    nxt_dec.dest_idx   = hw[`FLD_DEST_HI:`FLD_DEST_LO]; // RQ21
    nxt_dec.src_idx    = hw[`FLD_SRC_HI:`FLD_SRC_LO]; // RQ21
    nxt_dec.mem_access = 1'b1;
    case (req.mode)
      M_REG_DIRECT: begin
        nxt_dec.use_reg    = 1'b1; // RQ1
        nxt_dec.mem_access = 1'b0; // RQ1
      end
      M_REG_IND: nxt_dec.eff_addr = regs.dest_general_reg; // RQ2
      M_POST_INC: begin
        nxt_dec.eff_addr = regs.dest_general_reg; // RQ3
        nxt_dec.wb_en    = 1'b1;
        nxt_dec.wb_idx   = nxt_dec.dest_idx;
        nxt_dec.wb_val   = regs.dest_general_reg + step; // RQ3 RQ24
      end
      M_PRE_DEC: begin
        nxt_dec.eff_addr = regs.dest_general_reg - step; // RQ4 RQ24
        nxt_dec.wb_en    = 1'b1;
        nxt_dec.wb_idx   = nxt_dec.dest_idx;
        nxt_dec.wb_val   = regs.dest_general_reg - step; // RQ4
      end
      M_DISP4:
        nxt_dec.eff_addr = regs.dest_general_reg + disp4_scaled; // RQ5
      M_DISP12:
        nxt_dec.eff_addr = regs.dest_general_reg
                           + {20'h0_0000, req.insn[11:0]}; // RQ6
      M_IDX_REG:
        nxt_dec.eff_addr = regs.dest_general_reg
                           + regs.index_reg_zero; // RQ7
      M_GBR_DISP:
        nxt_dec.eff_addr = regs.global_base_reg + disp8_scaled; // RQ8
      M_GBR_IDX:
        nxt_dec.eff_addr = regs.global_base_reg
                           + regs.index_reg_zero; // RQ9
      M_TBR_DBL: begin
        nxt_dec.eff_addr = regs.jump_table_base_reg
                           + {22'h00_0000, hw[7:0], 2'b00}; // RQ10
        nxt_dec.indirect = 1'b1; // RQ10
      end
      M_PC_DISP: nxt_dec.eff_addr = pc_disp; // RQ11
      M_PC_REL8: begin
        nxt_dec.eff_addr   = regs.pc
                             + {{23{hw[7]}}, hw[7:0], 1'b0}; // RQ12
        nxt_dec.mem_access = 1'b0;
      end
      M_PC_REL12: begin
        nxt_dec.eff_addr   = regs.pc
                             + {{19{hw[11]}}, hw[11:0], 1'b0}; // RQ13
        nxt_dec.mem_access = 1'b0;
      end
      M_PC_REG: begin
        nxt_dec.eff_addr   = regs.pc + regs.dest_general_reg; // RQ14
        nxt_dec.mem_access = 1'b0;
      end
      M_IMM20: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.dest_idx   = req.insn[27:24]; // RQ23
        nxt_dec.imm        = {{12{imm20[19]}}, imm20}; // RQ15
      end
      M_IMM20S: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.dest_idx   = req.insn[27:24]; // RQ23
        nxt_dec.imm        = {{4{imm20[19]}}, imm20, 8'h00}; // RQ16
      end
      M_IMM8_ZX: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.imm        = {24'h00_0000, hw[7:0]}; // RQ17
      end
      M_IMM8_SX: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.imm        = {{24{hw[7]}}, hw[7:0]}; // RQ18
      end
      M_TRAP: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.imm        = {22'h00_0000, hw[7:0], 2'b00}; // RQ19
      end
      M_BIT3: begin
        nxt_dec.mem_access = 1'b0;
        nxt_dec.bit_pos    = hw[2:0]; // RQ20
      end
      M_MAC: begin
        // Both fields are source pointers; results go to the accumulators.
        nxt_dec.eff_addr = regs.src_general_reg;
        nxt_dec.acc_dest = 1'b1; // RQ22
        nxt_dec.wb_en    = 1'b1;
        nxt_dec.wb_idx   = nxt_dec.src_idx;
        nxt_dec.wb_val   = regs.src_general_reg + step;
        nxt_dec.wb2_en   = 1'b1; // RQ22
        nxt_dec.wb2_idx  = nxt_dec.dest_idx;
        nxt_dec.wb2_val  = regs.dest_general_reg + step; // RQ22
      end
      default: nxt_dec.mem_access = 1'b0;
    endcase
    if (!req_valid) begin
      nxt_dec = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dec_ff <= '0;
    end else begin
      dec_ff <= nxt_dec;
    end
  end

  assign dec_out = dec_ff;

  property p_post_inc;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_POST_INC && req.size == SZ_LONG) |=>
      (dec_out.wb_val == dec_out.eff_addr + 32'h0000_0004);
  endproperty
  a_post_inc: assert property (p_post_inc) // RQ3
    else $error("Post-increment step is wrong.");

  property p_pre_dec;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_PRE_DEC && req.size == SZ_WORD) |=>
      (dec_out.eff_addr == $past(regs.dest_general_reg) - 32'h0000_0002
       && dec_out.wb_val == dec_out.eff_addr);
  endproperty
  a_pre_dec: assert property (p_pre_dec) // RQ4
    else $error("Pre-decrement address is wrong.");

  property p_reg_direct;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_REG_DIRECT) |=>
      (dec_out.use_reg && !dec_out.mem_access && !dec_out.wb_en);
  endproperty
  a_reg_direct: assert property (p_reg_direct) // RQ1
    else $error("Register direct accessed memory.");

  property p_disp12;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_DISP12) |=>
      (dec_out.eff_addr == $past(regs.dest_general_reg)
       + {20'h0_0000, $past(req.insn[11:0])});
  endproperty
  a_disp12: assert property (p_disp12) // RQ6
    else $error("Long displacement address is wrong.");

  property p_gbr_idx;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_GBR_IDX) |=>
      (dec_out.eff_addr == $past(regs.global_base_reg)
       + $past(regs.index_reg_zero));
  endproperty
  a_gbr_idx: assert property (p_gbr_idx) // RQ9
    else $error("Indexed global-base address is wrong.");

  property p_imm20s;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_IMM20S) |=>
      (dec_out.imm[7:0] == 8'h00
       && dec_out.imm[31:28] == {4{dec_out.imm[27]}});
  endproperty
  a_imm20s: assert property (p_imm20s) // RQ16
    else $error("Shifted immediate layout is wrong.");

  property p_trap;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_TRAP) |=>
      (dec_out.imm[1:0] == 2'b00 && dec_out.imm[31:10] == 22'h00_0000);
  endproperty
  a_trap: assert property (p_trap) // RQ19
    else $error("Trap vector offset is wrong.");

  property p_pc_long;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_PC_DISP && req.size == SZ_LONG) |=>
      (dec_out.eff_addr[1:0] == 2'b00);
  endproperty
  a_pc_long: assert property (p_pc_long) // RQ11
    else $error("Longword counter address not aligned.");

  property p_mac;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_MAC) |=>
      (dec_out.acc_dest && dec_out.wb_idx == dec_out.src_idx
       && dec_out.wb2_en && dec_out.wb2_idx == dec_out.dest_idx);
  endproperty
  a_mac: assert property (p_mac) // RQ22
    else $error("Accumulate pointer updates are wrong.");

  property p_rel8;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_PC_REL8) |=>
      (dec_out.eff_addr == $past(regs.pc)
       + {{23{$past(req.insn[7])}}, $past(req.insn[7:0]), 1'b0});
  endproperty
  a_rel8: assert property (p_rel8) // RQ12
    else $error("Short branch target is wrong.");

  property p_disp4;
    @(posedge sys_clk) disable iff (reset)
    (req_valid && req.mode == M_DISP4 && req.size == SZ_LONG) |=>
      (dec_out.eff_addr == $past(regs.dest_general_reg)
       + {26'h000_0000, $past(req.insn[3:0]), 2'b00});
  endproperty
  a_disp4: assert property (p_disp4) // RQ5
    else $error("Short displacement address is wrong.");

  property p_idle;
    @(posedge sys_clk) disable iff (reset)
    !req_valid |=> !dec_out.valid && !dec_out.wb_en;
  endproperty
  a_idle: assert property (p_idle)
    else $error("Output valid without a request.");

  c_post_inc: cover property (@(posedge sys_clk) disable iff (reset)
    req_valid && req.mode == M_POST_INC);
  c_tbr: cover property (@(posedge sys_clk) disable iff (reset)
    req_valid && req.mode == M_TBR_DBL);
  c_mac: cover property (@(posedge sys_clk) disable iff (reset)
    req_valid && req.mode == M_MAC);
  c_rel12_neg: cover property (@(posedge sys_clk) disable iff (reset)
    req_valid && req.mode == M_PC_REL12 && req.insn[11]);

endmodule : operand_address_decoder

// ---- dv/regfile_model.sv ----
// Register file and counter model on the far side of the decoder.
// Assumes requests change just after the rising edge of sys_clk.
`timescale 1ns/10ps
module regfile_model
  import opaddr_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      reset,
  input  wire logic      req_valid,
  input  wire dec_req_t  req,
  input  wire dec_out_t  dec_out,
  output reg_vals_t      regs
);
  localparam logic [31:0] GBASE = 32'hFFFF_FF80;
  localparam logic [31:0] TBASE = 32'h0000_4000;
  logic [31:0] gpr_ff [16];
  logic [31:0] pc_ff;

  // Register 15, the global base and the counter sit near the top of the space so that address sums wrap.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 15; i++) begin
        gpr_ff[i] <= 32'h1357_9BDF * (i + 1);
      end
      gpr_ff[15] <= 32'hFFFF_FFFE;
    end else begin
      if (dec_out.wb_en) begin
        gpr_ff[dec_out.wb_idx] <= dec_out.wb_val;
      end
      if (dec_out.wb2_en) begin
        gpr_ff[dec_out.wb2_idx] <= dec_out.wb2_val;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pc_ff <= 32'hFFFF_FF00;
    end else if (req_valid) begin
      pc_ff <= pc_ff + 32'h0000_0016;
    end
  end

  // Outside a request the read port shows junk, not the last value.
  always_comb begin
    regs.dest_general_reg    = gpr_ff[req.insn[11:8]];
    regs.src_general_reg     = gpr_ff[req.insn[7:4]];
    regs.index_reg_zero      = gpr_ff[0];
    regs.global_base_reg     = GBASE;
    regs.jump_table_base_reg = TBASE;
    regs.pc                  = pc_ff;
    if (!req_valid) begin
      regs = {6{~pc_ff}};
    end
  end
endmodule : regfile_model

// ---- dv/tb_top.sv ----
// Bench for the operand address decoder: random requests, queued checks.
// Assumes the package, the decoder and regfile_model are compiled first.
`timescale 1ns/10ps
module tb_top;
  import opaddr_pkg::*;
  typedef struct {addr_mode_t m; logic [31:0] v, w, w2, w3;} exp_t;
  logic        sys_clk;
  logic        reset;
  logic        req_valid;
  logic        vld_ff;
  dec_req_t    req;
  reg_vals_t   regs;
  dec_out_t    dec_out;
  exp_t        q[$];
  exp_t        e;
  logic [31:0] lfsr_ff;
  logic [10:0] wb_seen;
  int          fail_count = 0;
  int          n_compared = 0;

  operand_address_decoder dut (.sys_clk(sys_clk), .reset(reset),
    .req_valid(req_valid), .req(req), .regs(regs), .dec_out(dec_out));
  regfile_model far_end (.sys_clk(sys_clk), .reset(reset),
    .req_valid(req_valid), .req(req), .dec_out(dec_out), .regs(regs));
  assign wb_seen = {dec_out.acc_dest, dec_out.wb_en, dec_out.wb_idx,
                    dec_out.wb2_en, dec_out.wb2_idx};

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  function automatic exp_t exp_of(dec_req_t r, reg_vals_t g);
    logic [31:0] st, rn, d8;
    logic [19:0] i20;
    exp_t x;
    st = 32'h0000_0001 << r.size;
    rn = g.dest_general_reg;
    d8 = 32'(r.insn[7:0]);
    i20 = {r.insn[23:20], r.insn[15:0]};
    x.m = r.mode;
    x.v = '0;
    x.w = rn + st;
    x.w2 = 32'(r.insn[11:4]);
    x.w3 = 32'({2'b01, r.insn[11:8], 5'h00});
    case (r.mode)
      M_REG_DIRECT: x.v = 32'h0000_0002;
      M_REG_IND, M_POST_INC: x.v = rn;
      M_PRE_DEC: x.v = rn - st;
      M_DISP4: x.v = rn + (32'(r.insn[3:0]) << r.size);
      M_DISP12: x.v = rn + 32'(r.insn[11:0]);
      M_IDX_REG: x.v = rn + g.index_reg_zero;
      M_GBR_DISP: x.v = g.global_base_reg + (d8 << r.size);
      M_GBR_IDX: x.v = g.global_base_reg + g.index_reg_zero;
      M_TBR_DBL: x.v = g.jump_table_base_reg + (d8 << 2);
      M_PC_DISP: x.v = (r.size == SZ_LONG) ?
        (g.pc & 32'hFFFF_FFFC) + (d8 << 2) : g.pc + (d8 << 1);
      M_PC_REL8: x.v = g.pc + (32'(signed'(r.insn[7:0])) << 1);
      M_PC_REL12: x.v = g.pc + (32'(signed'(r.insn[11:0])) << 1);
      M_PC_REG: x.v = g.pc + rn;
      M_IMM20: x.v = 32'(signed'(i20));
      M_IMM20S: x.v = {{4{i20[19]}}, i20, 8'h00};
      M_IMM8_ZX: x.v = d8;
      M_IMM8_SX: x.v = 32'(signed'(r.insn[7:0]));
      M_TRAP: x.v = d8 << 2;
      M_BIT3: x.v = 32'(r.insn[2:0]);
      M_MAC: begin
        x.v = g.src_general_reg;
        x.w = g.src_general_reg + st;
        x.w2 = rn + st;
        x.w3 = 32'({2'b11, r.insn[7:4], 1'b1, r.insn[11:8]});
      end
      default: x.v = '0;
    endcase
    if (r.mode == M_PRE_DEC) begin
      x.w = x.v;
    end
    if (r.mode == M_IMM20 || r.mode == M_IMM20S) begin
      x.w2 = 32'(r.insn[27:24]);
    end
    return x;
  endfunction : exp_of

  always @(posedge sys_clk) begin
    vld_ff <= reset ? 1'b0 : req_valid;
  end

  always @(negedge sys_clk) begin
    if (!reset) begin
      chk(32'(dec_out.valid), 32'(vld_ff));
      if (dec_out.valid === 1'b1 && q.size() > 0) begin
        e = q.pop_front();
        case (e.m)
          M_REG_DIRECT:
            chk(32'({dec_out.use_reg, dec_out.mem_access}), e.v);
          M_POST_INC, M_PRE_DEC, M_MAC: begin
            chk(dec_out.wb_val, e.w);
            chk(32'(wb_seen), e.w3);
          end
          M_DISP4:
            chk(32'({dec_out.dest_idx, dec_out.src_idx}), e.w2);
          M_IMM20, M_IMM20S: chk(32'(dec_out.dest_idx), e.w2);
          M_TBR_DBL: chk(32'(dec_out.indirect), 32'h0000_0001);
          M_BIT3: chk(32'(dec_out.bit_pos), e.v);
          default: ;
        endcase
        case (e.m)
          M_REG_DIRECT, M_BIT3: ;
          M_IMM20, M_IMM20S: chk(dec_out.imm, e.v);
          M_IMM8_ZX, M_IMM8_SX, M_TRAP:
            chk(dec_out.imm, e.v);
          M_PC_DISP, M_PC_REL8, M_PC_REL12, M_PC_REG:
            chk(dec_out.eff_addr, e.v);
          M_MAC: chk(dec_out.wb2_val, e.w2);
          default:
            chk(dec_out.eff_addr, e.v);
        endcase
      end
    end
  end

  initial begin
    dec_req_t r;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lfsr_ff = 32'h0000_0007;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk(32'(|dec_out), 32'h0000_0000);
    @(posedge sys_clk);
    // Two slots per mode in each of five rounds, every seventh slot idle, otherwise back to back.
    for (int k = 0; k < 210; k++) begin
      lfsr_ff = lfsr(lfsr_ff);
      r.mode = addr_mode_t'(5'((k / 2) % 21));
      r.size = (lfsr_ff[1:0] == 2'b11) ? SZ_LONG
                                       : access_size_t'(lfsr_ff[1:0]);
      if (r.mode == M_PC_DISP) begin
        r.size = lfsr_ff[0] ? SZ_LONG : SZ_WORD;
      end
      r.insn = lfsr(lfsr_ff ^ 32'h5A5A_0F0F);
      if (r.mode != M_MAC) begin
        r.insn[7:4] = r.insn[11:8];
      end
      req <= r;
      req_valid <= (k % 7 != 6);
      @(negedge sys_clk);
      if (req_valid) begin
        q.push_back(exp_of(req, regs));
      end
      @(posedge sys_clk);
    end
    req_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(q.size()), 32'h0000_0000);
    chk(32'(|dec_out), 32'h0000_0000);
    finish_test();
  end

  initial begin
    #(4 * 2000);
    fail_count++;
    finish_test();
  end
endmodule : tb_top
